// File: nbp_params.svh
// Constants for the flash block protection command controller
`ifndef NBP_PARAMS_SVH
`define NBP_PARAMS_SVH

// System clock period in ns
`define NBP_CLK_NS         10.0
// Flash data bus width and block field position
`define NBP_DQ_W           16
`define NBP_BLK_LSB        12

// Software register offsets
`define NBP_REG_CMD        8'h00
`define NBP_REG_BLK        8'h04
`define NBP_REG_DATA       8'h08
`define NBP_REG_PORT       8'h0C
`define NBP_REG_STAT       8'h10
`define NBP_REG_RES        8'h14
`define NBP_REG_PW         8'h20
// Status bit positions
`define NBP_ST_BUSY        0
`define NBP_ST_DONE        1
`define NBP_ST_FAIL        2
`define NBP_ST_TRIES       4
// Reset values
`define NBP_RST_WORD       16'h0000
`define NBP_RST_TRIES      4'h0

// Unlock cycle addresses and data
`define NBP_ADR_UNL1       12'h555
`define NBP_ADR_UNL2       12'h2AA
`define NBP_DAT_UNL1       16'h00AA
`define NBP_DAT_UNL2       16'h0055
// Command codes
`define NBP_CMD_PW_PROG    16'h0038
`define NBP_CMD_PW_VERIFY  16'h00C8
`define NBP_CMD_PW_UNLOCK  16'h0028
`define NBP_CMD_BIT_PROG   16'h0060
`define NBP_CMD_MASTER     16'h00F1
`define NBP_CMD_PPB_STAT   16'h0090
`define NBP_CMD_LOCK_SET   16'h0078
`define NBP_CMD_STATUS     16'h0058
`define NBP_CMD_DYB        16'h0048
// Data of the later cycles
`define NBP_DAT_PROG1      16'h0068
`define NBP_DAT_PROG2      16'h0048
`define NBP_DAT_ERASE1     16'h0060
`define NBP_DAT_ERASE2     16'h0040
`define NBP_DAT_DYB_SET    16'h0001
`define NBP_DAT_DYB_CLR    16'h0000
// Low address of the protection bits
`define NBP_ADR_PPB        12'h002
`define NBP_ADR_PML        12'h00A
`define NBP_ADR_SML        12'h012
`define NBP_ADR_BLK        12'h000

// Least waits
`define NBP_T_PW_GAP_US    2
`define NBP_T_PROG_US      100
`define NBP_T_ERASE_MS     1.2

`endif

// File: nbp_pkg.sv
// Types of the flash block protection command controller
`include "nbp_params.svh"
package nbp_pkg;
	typedef enum logic [3:0] {
		nbp_pw_prog, nbp_pw_verify, nbp_pw_unlock, nbp_ppb_prog,
		nbp_master_set, nbp_ppb_status, nbp_ppb_erase, nbp_lock_set,
		nbp_lock_status, nbp_dyb_set, nbp_dyb_clear, nbp_dyb_status,
		nbp_pml_prog, nbp_pml_status, nbp_sml_prog, nbp_sml_status
	} nbp_op_t;
	typedef enum logic [1:0] {nbp_k_write, nbp_k_read, nbp_k_end} nbp_kind_t;
	typedef struct packed {
		nbp_kind_t             kind;
		logic [11:0]           low;
		logic [`NBP_DQ_W-1:0]  dat;
	} nbp_step_t;
endpackage

// File: nbp_bus_cycle.sv
// One asynchronous flash bus cycle, write or read
`timescale 1ns/1ps
`include "nbp_params.svh"
module nbp_bus_cycle #(
	parameter int ADDR_W     = 21,
	parameter int STROBE_CYC = 4
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic                 start_i,
	input  wire logic                 read_i,
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic [`NBP_DQ_W-1:0] data_i,
	output logic                      done_o,
	output logic [`NBP_DQ_W-1:0]      rdata_o,
	output logic [ADDR_W-1:0]         flash_addr_o,
	input  wire logic [`NBP_DQ_W-1:0] flash_dq_i,
	output logic [`NBP_DQ_W-1:0]      flash_dq_o,
	output logic                      flash_dq_oe_o,
	output logic                      flash_ce_n_o,
	output logic                      flash_we_n_o,
	output logic                      flash_oe_n_o
);
	typedef enum logic [1:0] {bc_idle, bc_setup, bc_strobe, bc_hold}
		nbp_bc_state_t;

	nbp_bc_state_t state;
	logic [4:0]    cnt;
	logic          rd;

	if (STROBE_CYC < 1 || STROBE_CYC > 16) begin : g_bad_strobe
		$error("Strobe length must be 1 to 16 cycles");
	end

	// Setup, strobe, then a hold cycle with data still driven
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state         <= bc_idle;
			cnt           <= 5'h00;
			rd            <= 1'b0;
			done_o        <= 1'b0;
			rdata_o       <= `NBP_RST_WORD;
			flash_addr_o  <= '0;
			flash_dq_o    <= `NBP_RST_WORD;
			flash_dq_oe_o <= 1'b0;
			flash_ce_n_o  <= 1'b1;
			flash_we_n_o  <= 1'b1;
			flash_oe_n_o  <= 1'b1;
		end else if (ce_i) begin
			done_o <= 1'b0;
			unique case (state)
				bc_idle: if (start_i) begin
					flash_addr_o  <= addr_i;
					flash_dq_o    <= data_i;
					rd            <= read_i;
					flash_ce_n_o  <= 1'b0;
					flash_dq_oe_o <= !read_i;
					state         <= bc_setup;
				end
				bc_setup: begin
					flash_we_n_o <= rd;
					flash_oe_n_o <= !rd;
					cnt          <= 5'(STROBE_CYC - 1);
					state        <= bc_strobe;
				end
				bc_strobe: if (cnt == 5'h00) begin
					// Device latches on the rising write strobe
					flash_we_n_o <= 1'b1;
					flash_oe_n_o <= 1'b1;
					if (rd) begin
						rdata_o <= flash_dq_i;
					end
					state <= bc_hold;
				end else begin
					cnt <= cnt - 5'h01;
				end
				bc_hold: begin
					flash_ce_n_o  <= 1'b1;
					flash_dq_oe_o <= 1'b0;
					done_o        <= 1'b1;
					state         <= bc_idle;
				end
			endcase
		end
	end

	// Checks on the pin protocol
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_strobe_excl: assert property (flash_we_n_o || flash_oe_n_o)
		else $error("Write and read strobes low together");
	a_write_drive: assert property (!flash_we_n_o |-> flash_dq_oe_o
		&& !flash_ce_n_o)
		else $error("Write strobe low without data driven");
	a_we_rise_data: assert property ($rose(flash_we_n_o) |->
		flash_dq_oe_o && $stable(flash_dq_o))
		else $error("Data changed at write strobe rise");
	c_read_cycle: cover property ($rose(flash_oe_n_o) ##1 done_o);
endmodule

// File: nbp_ctrl.sv
// Host controller issuing flash block protection command sequences
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "nbp_params.svh"
module nbp_ctrl #(
	parameter int ADDR_W     = 21,
	parameter int STROBE_CYC = 4,
	parameter int MAX_TRIES  = 4,
	parameter int PROG_WAIT  =
		int'($ceil(`NBP_T_PROG_US * 1000.0 / `NBP_CLK_NS)),
	parameter int ERASE_WAIT =
		int'($ceil(`NBP_T_ERASE_MS * 1.0e6 / `NBP_CLK_NS))
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic [7:0]           sw_addr_i,
	input  wire logic [31:0]          sw_wdata_i,
	input  wire logic                 sw_wr_i,
	input  wire logic                 sw_rd_i,
	output logic [31:0]               sw_rdata_o,
	output logic [ADDR_W-1:0]         flash_addr_o,
	input  wire logic [`NBP_DQ_W-1:0] flash_dq_i,
	output logic [`NBP_DQ_W-1:0]      flash_dq_o,
	output logic                      flash_dq_oe_o,
	output logic                      flash_ce_n_o,
	output logic                      flash_we_n_o,
	output logic                      flash_oe_n_o
);
	localparam int BLK_W    = ADDR_W - `NBP_BLK_LSB;
	localparam int GAP_WAIT =
		int'($ceil(`NBP_T_PW_GAP_US * 1000.0 / `NBP_CLK_NS));

	typedef enum logic [1:0] {st_idle, st_issue, st_cycle, st_wait}
		nbp_state_t;

	if (BLK_W < 1 || BLK_W > 32 || MAX_TRIES < 1 || MAX_TRIES > 15 ||
		PROG_WAIT < 1 || ERASE_WAIT < 1) begin : g_bad_param
		$error("Unsupported controller parameters");
	end

	nbp_state_t              state;
	nbp_pkg::nbp_op_t        op_q;
	logic [2:0]              step;
	logic [3:0]              tries;
	logic [31:0]             wait_cnt;
	logic [31:0]             gap_cnt;
	logic [BLK_W-1:0]        blk;
	logic [`NBP_DQ_W-1:0]    wdat;
	logic [1:0]              portion;
	logic [`NBP_DQ_W-1:0]    pw [4];
	logic [`NBP_DQ_W-1:0]    result;
	logic                    done;
	logic                    fail;
	nbp_pkg::nbp_step_t      cur;
	logic [1:0]              pw_idx;
	logic                    start;
	logic                    cyc_done;
	logic [`NBP_DQ_W-1:0]    cyc_rdata;
	logic                    cmd_wr;
	logic                    stat_wr;
	logic                    finish;
	logic                    chk;
	logic                    ok;
	logic                    retry;
	logic                    complete;

	// Builds one step of a sequence
	function automatic nbp_pkg::nbp_step_t mk(input nbp_pkg::nbp_kind_t k,
		input logic [11:0] a, input logic [`NBP_DQ_W-1:0] d);
		mk = '{kind: k, low: a, dat: d};
	endfunction

	function automatic logic is_prog(input nbp_pkg::nbp_op_t op);
		is_prog = op == nbp_pkg::nbp_ppb_prog ||
			op == nbp_pkg::nbp_pml_prog || op == nbp_pkg::nbp_sml_prog;
	endfunction

	// Command code of the third cycle
	function automatic logic [`NBP_DQ_W-1:0] cmd_of(
		input nbp_pkg::nbp_op_t op);
		unique case (op)
			nbp_pkg::nbp_pw_prog:     cmd_of = `NBP_CMD_PW_PROG;
			nbp_pkg::nbp_pw_verify:   cmd_of = `NBP_CMD_PW_VERIFY;
			nbp_pkg::nbp_pw_unlock:   cmd_of = `NBP_CMD_PW_UNLOCK;
			nbp_pkg::nbp_master_set:  cmd_of = `NBP_CMD_MASTER;
			nbp_pkg::nbp_ppb_status:  cmd_of = `NBP_CMD_PPB_STAT;
			nbp_pkg::nbp_lock_set:    cmd_of = `NBP_CMD_LOCK_SET;
			nbp_pkg::nbp_lock_status,
			nbp_pkg::nbp_dyb_status:  cmd_of = `NBP_CMD_STATUS;
			nbp_pkg::nbp_dyb_set,
			nbp_pkg::nbp_dyb_clear:   cmd_of = `NBP_CMD_DYB;
			nbp_pkg::nbp_ppb_prog, nbp_pkg::nbp_ppb_erase,
			nbp_pkg::nbp_pml_prog, nbp_pkg::nbp_pml_status,
			nbp_pkg::nbp_sml_prog,
			nbp_pkg::nbp_sml_status:  cmd_of = `NBP_CMD_BIT_PROG;
		endcase
	endfunction

	// Least wait before step n, zero when none
	function automatic int gap_of(input nbp_pkg::nbp_op_t op,
		input logic [2:0] n);
		if (is_prog(op) && n == 3'd4) begin
			gap_of = PROG_WAIT;
		end else if (op == nbp_pkg::nbp_ppb_erase && n == 3'd4) begin
			gap_of = ERASE_WAIT;
		end else if (op == nbp_pkg::nbp_pw_unlock && n >= 3'd4 &&
			n <= 3'd6) begin
			gap_of = GAP_WAIT;
		end else begin
			gap_of = 0;
		end
	endfunction

	// Address low part and data of step st; upper data bits zero except in password writes
	function automatic nbp_pkg::nbp_step_t step_of(
		input nbp_pkg::nbp_op_t op, input logic [2:0] st,
		input logic [1:0] prt, input logic [`NBP_DQ_W-1:0] wd,
		input logic [`NBP_DQ_W-1:0] password_portion_data);
		logic [11:0] loc;
		loc = op == nbp_pkg::nbp_pml_prog || op == nbp_pkg::nbp_pml_status ?
			`NBP_ADR_PML :
			op == nbp_pkg::nbp_sml_prog || op == nbp_pkg::nbp_sml_status ?
			`NBP_ADR_SML : `NBP_ADR_PPB;
		step_of = mk(nbp_pkg::nbp_k_end, `NBP_ADR_BLK, `NBP_RST_WORD);
		if (st == 3'd0) begin
			step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_UNL1,
				`NBP_DAT_UNL1);
		end else if (st == 3'd1) begin
			step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_UNL2,
				`NBP_DAT_UNL2);
		end else if (st == 3'd2) begin
			step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_UNL1,
				cmd_of(op));
		end else begin
			unique case (op)
				nbp_pkg::nbp_pw_prog: if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_write, {10'h000, prt}, wd);
				end
				nbp_pkg::nbp_pw_verify: if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_read, {10'h000, prt},
						`NBP_RST_WORD);
				end
				nbp_pkg::nbp_pw_unlock: if (st <= 3'd6) begin
					step_of = mk(nbp_pkg::nbp_k_write,
						{10'h000, 2'(st - 3'd3)}, password_portion_data);
				end
				nbp_pkg::nbp_ppb_prog, nbp_pkg::nbp_pml_prog,
				nbp_pkg::nbp_sml_prog: begin
					if (st == 3'd3) begin
						step_of = mk(nbp_pkg::nbp_k_write, loc,
							`NBP_DAT_PROG1);
					end else if (st == 3'd4) begin
						step_of = mk(nbp_pkg::nbp_k_write, loc,
							`NBP_DAT_PROG2);
					end else if (st == 3'd5) begin
						step_of = mk(nbp_pkg::nbp_k_read, loc,
							`NBP_RST_WORD);
					end
				end
				nbp_pkg::nbp_ppb_erase: begin
					if (st == 3'd3) begin
						step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_PPB,
							`NBP_DAT_ERASE1);
					end else if (st == 3'd4) begin
						step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_PPB,
							`NBP_DAT_ERASE2);
					end else if (st == 3'd5) begin
						step_of = mk(nbp_pkg::nbp_k_read, `NBP_ADR_PPB,
							`NBP_RST_WORD);
					end
				end
				nbp_pkg::nbp_ppb_status: if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_read, `NBP_ADR_PPB,
						`NBP_RST_WORD);
				end
				nbp_pkg::nbp_lock_status, nbp_pkg::nbp_dyb_status:
					if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_read, `NBP_ADR_BLK,
						`NBP_RST_WORD);
				end
				nbp_pkg::nbp_dyb_set: if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_BLK,
						`NBP_DAT_DYB_SET);
				end
				nbp_pkg::nbp_dyb_clear: if (st == 3'd3) begin
					step_of = mk(nbp_pkg::nbp_k_write, `NBP_ADR_BLK,
						`NBP_DAT_DYB_CLR);
				end
				nbp_pkg::nbp_pml_status, nbp_pkg::nbp_sml_status: begin
					if (st == 3'd3) begin
						step_of = mk(nbp_pkg::nbp_k_write, loc,
							`NBP_DAT_PROG2);
					end else if (st == 3'd4) begin
						step_of = mk(nbp_pkg::nbp_k_read, loc,
							`NBP_RST_WORD);
					end
				end
				nbp_pkg::nbp_master_set, nbp_pkg::nbp_lock_set: ;
			endcase
		end
	endfunction

	// Current step and its outcome
	assign pw_idx   = 2'(step - 3'd3);
	assign cur      = step_of(op_q, step, portion, wdat, pw[pw_idx]);
	assign start    = state == st_issue && cur.kind != nbp_pkg::nbp_k_end;
	assign cmd_wr   = sw_wr_i && sw_addr_i == `NBP_REG_CMD;
	assign stat_wr  = sw_wr_i && sw_addr_i == `NBP_REG_STAT;
	assign finish   = state == st_issue && cur.kind == nbp_pkg::nbp_k_end;
	assign chk      = is_prog(op_q) || op_q == nbp_pkg::nbp_ppb_erase;
	assign ok       = is_prog(op_q) ? result[0] : !result[0];
	assign retry    = finish && chk && !ok && tries < 4'(MAX_TRIES);
	assign complete = finish && !retry;

	// Block address drives the bits from A12 upward
	nbp_bus_cycle #(
		.ADDR_W     (ADDR_W),
		.STROBE_CYC (STROBE_CYC)
	) u_cycle (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.ce_i          (ce_i),
		.start_i       (start),
		.read_i        (cur.kind == nbp_pkg::nbp_k_read),
		.addr_i        ({blk, cur.low}),
		.data_i        (cur.dat),
		.done_o        (cyc_done),
		.rdata_o       (cyc_rdata),
		.flash_addr_o  (flash_addr_o),
		.flash_dq_i    (flash_dq_i),
		.flash_dq_o    (flash_dq_o),
		.flash_dq_oe_o (flash_dq_oe_o),
		.flash_ce_n_o  (flash_ce_n_o),
		.flash_we_n_o  (flash_we_n_o),
		.flash_oe_n_o  (flash_oe_n_o)
	);

	// Operand registers; held steady while a sequence runs
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			blk     <= '0;
			wdat    <= `NBP_RST_WORD;
			portion <= 2'b00;
			pw      <= '{default: `NBP_RST_WORD};
		end else if (ce_i && sw_wr_i && state == st_idle) begin
			if (sw_addr_i == `NBP_REG_BLK) begin
				blk <= sw_wdata_i[BLK_W-1:0];
			end
			if (sw_addr_i == `NBP_REG_DATA) begin
				wdat <= sw_wdata_i[`NBP_DQ_W-1:0];
			end
			if (sw_addr_i == `NBP_REG_PORT) begin
				portion <= sw_wdata_i[1:0];
			end
			if (sw_addr_i[7:4] == `NBP_REG_PW >> 4) begin
				pw[sw_addr_i[3:2]] <= sw_wdata_i[`NBP_DQ_W-1:0];
			end
		end
	end

	// Sequencer; a command write while busy is dropped
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state    <= st_idle;
			op_q     <= nbp_pkg::nbp_pw_prog;
			step     <= 3'd0;
			tries    <= `NBP_RST_TRIES;
			wait_cnt <= 32'h0000_0000;
			result   <= `NBP_RST_WORD;
		end else if (ce_i) begin
			unique case (state)
				st_idle: if (cmd_wr) begin
					op_q  <= nbp_pkg::nbp_op_t'(sw_wdata_i[3:0]);
					step  <= 3'd0;
					tries <= 4'h1;
					state <= st_issue;
				end
				st_issue: if (finish) begin
					if (retry) begin
						step  <= 3'd0;
						tries <= tries + 4'h1;
					end else begin
						state <= st_idle;
					end
				end else begin
					state <= st_cycle;
				end
				st_cycle: if (cyc_done) begin
					if (cur.kind == nbp_pkg::nbp_k_read) begin
						result <= cyc_rdata;
					end
					step <= step + 3'd1;
					if (gap_of(op_q, step + 3'd1) != 0) begin
						wait_cnt <= 32'(gap_of(op_q, step + 3'd1) - 1);
						state    <= st_wait;
					end else begin
						state <= st_issue;
					end
				end
				st_wait: if (wait_cnt == 32'h0000_0000) begin
					state <= st_issue;
				end else begin
					wait_cnt <= wait_cnt - 32'h0000_0001;
				end
			endcase
		end
	end

	// Completion flags; completion wins over a clear in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			done <= 1'b0;
			fail <= 1'b0;
		end else if (ce_i) begin
			if (complete) begin
				done <= 1'b1;
				fail <= chk && !ok;
			end else if (cmd_wr && state == st_idle) begin
				done <= 1'b0;
				fail <= 1'b0;
			end else if (stat_wr && sw_wdata_i[`NBP_ST_DONE]) begin
				done <= 1'b0;
			end
		end
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sw_rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			sw_rdata_o <= 32'h0000_0000;
			if (sw_rd_i) begin
				if (sw_addr_i == `NBP_REG_CMD) begin
					sw_rdata_o <= {28'h000_0000, op_q};
				end else if (sw_addr_i == `NBP_REG_BLK) begin
					sw_rdata_o <= 32'(blk);
				end else if (sw_addr_i == `NBP_REG_DATA) begin
					sw_rdata_o <= {16'h0000, wdat};
				end else if (sw_addr_i == `NBP_REG_PORT) begin
					sw_rdata_o <= {30'h0000_0000, portion};
				end else if (sw_addr_i == `NBP_REG_STAT) begin
					sw_rdata_o <= {24'h00_0000, tries, 1'b0, fail, done,
						state != st_idle};
				end else if (sw_addr_i == `NBP_REG_RES) begin
					sw_rdata_o <= {16'h0000, result};
				end else if (sw_addr_i[7:4] == `NBP_REG_PW >> 4) begin
					sw_rdata_o <= {16'h0000, pw[sw_addr_i[3:2]]};
				end
			end
		end
	end

	// Helper: cycles since the last bus cycle ended, saturating
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			gap_cnt <= 32'h0000_0000;
		end else if (ce_i) begin
			if (cyc_done) begin
				gap_cnt <= 32'h0000_0000;
			end else if (gap_cnt != 32'hFFFF_FFFF) begin
				gap_cnt <= gap_cnt + 32'h0000_0001;
			end
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_first_unlock: assert property (ce_i && start && step == '0 |=>
		flash_addr_o[11:0] == `NBP_ADR_UNL1 && flash_dq_o == `NBP_DAT_UNL1)
		else $error("First cycle is not the unlock write");
	a_cmd_cycle: assert property (start && step == 3'd2 |->
		cur.low == `NBP_ADR_UNL1 && cur.dat[15:8] == 8'h00)
		else $error("Command cycle malformed");
	a_unlock_gap: assert property (start &&
		op_q == nbp_pkg::nbp_pw_unlock && step >= 3'd4 |->
		gap_cnt >= GAP_WAIT)
		else $error("Password portions too close");
	a_prog_gap: assert property (start && is_prog(op_q) &&
		step == 3'd4 |-> gap_cnt >= PROG_WAIT)
		else $error("Program wait too short");
	a_erase_gap: assert property (start && step == 3'd4 &&
		op_q == nbp_pkg::nbp_ppb_erase |-> gap_cnt >= ERASE_WAIT)
		else $error("Erase wait too short");
	a_retry_bound: assert property (state != st_idle |->
		tries >= 4'h1 && tries <= 4'(MAX_TRIES))
		else $error("Try count out of range");
	a_unlock_data: assert property (start && step >= 3'd3 &&
		op_q == nbp_pkg::nbp_pw_unlock |->
		cur.dat == pw[pw_idx] && cur.low[1:0] == pw_idx)
		else $error("Wrong password portion sent");
	a_short_end: assert property (finish &&
		(op_q == nbp_pkg::nbp_master_set ||
		op_q == nbp_pkg::nbp_lock_set) |-> step == 3'd3)
		else $error("Three-cycle command has wrong length");
	a_busy_ignore: assert property (ce_i && state != st_idle && cmd_wr
		|=> op_q == $past(op_q))
		else $error("Command taken while busy");
	a_result_read: assert property (ce_i && sw_rd_i &&
		sw_addr_i == `NBP_REG_RES |=> sw_rdata_o[15:0] == $past(result))
		else $error("Result read back wrong");

	c_unlock_done: cover property (complete &&
		op_q == nbp_pkg::nbp_pw_unlock);
	c_retry: cover property (retry);
	c_prog_pass: cover property (complete && is_prog(op_q) && ok);
endmodule

// File: nbp_flash_model.sv
// Protection command model of the flash device
`timescale 1ns/1ps
module nbp_flash_model #(
	parameter int PROG_NS = 200
) (
	input  wire logic [20:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic [15:0]      dq_o,
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        drv_i
);
	logic [63:0] pw = 0, ub = 0;
	logic [511:0] persistent_protect_bit = 0, dynamic_protect_bit = 0;
	logic [15:0] val, last = 0;
	logic [7:0] cmd = 0, a, d;
	logic lock = 0, pml = 0, sml = 0, master = 0;
	int n = 0, bad = 0, late = 0;
	realtime tw = 0;
	wire [8:0] b = addr_i[20:12];
	// Decoder, latched on the rising write strobe
	always @(posedge we_n_i) if (!ce_n_i) begin
		if (!drv_i) late++;
		a = addr_i[7:0];
		d = dq_i[7:0];
		if (n == 0)
			n = int'(addr_i[11:0] == 12'h555 && d == 8'hAA);
		else if (n == 1)
			n = (addr_i[11:0] == 12'h2AA && d == 8'h55) ? 2 : 0;
		else if (n == 2) begin
			cmd = d;
			if (d == 8'hF1) master = 1;
			if (d == 8'h78) lock = 1;
			n = (addr_i[11:0] == 12'h555 && d != 8'hF1 && d != 8'h78) ? 3 : 0;
		end else begin
			if (cmd == 8'h38 && !pml) pw[16*a[1:0] +: 16] = dq_i;
			if (cmd == 8'h48) dynamic_protect_bit[b] = d[0];
			if (cmd == 8'h28) ub[16*(n-3) +: 16] = dq_i;
			if (cmd == 8'h28 && n > 3 && $realtime - tw < 2000) late++;
			if (cmd == 8'h60 && n == 4 && $realtime - tw < PROG_NS) late++;
			if (cmd == 8'h60 && d == 8'h60) persistent_protect_bit = 0;
			if (cmd == 8'h60 && d == 8'h68) case (a)
				8'h02: persistent_protect_bit[b] = 1;
				8'h0A: pml = 1;
				8'h12: sml = 1;
				default: ;
			endcase
			n = (cmd == 8'h38 || cmd == 8'h48) ? 0 : n + 1;
			if (n == 7) begin
				if (ub == pw && !sml) lock = 0;
				n = 0;
			end
		end
		tw = $realtime;
	end
	// Read data picked by the command in progress
	always_comb begin
		case (cmd)
			8'hC8: val = pml ? 16'hFFFF : pw[16*addr_i[1:0] +: 16];
			8'h90: val = 16'(persistent_protect_bit[b]);
			8'h58: val = 16'({lock, dynamic_protect_bit[b]});
			default: val = 16'(addr_i[7:0] == 8'h0A ? pml :
				addr_i[7:0] == 8'h12 ? sml : persistent_protect_bit[b]);
		endcase
		val[0] = val[0] ^ (bad > 0);
	end
	// Released bus shows a changed value, never the last one
	assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
	always @(posedge oe_n_i) begin
		if (drv_i) late++;
		last = val;
		n = 0;
		if (bad > 0) bad--;
	end
endmodule

// File: nbp_ctrl_bench.sv
// Bench for the protection command controller
`timescale 1ns/1ps
module nbp_ctrl_bench;
	logic clk_sys_i = 0, rst_i = 1, sw_wr_i = 0, sw_rd_i = 0;
	logic [7:0] sw_addr_i = 0;
	logic [31:0] sw_wdata_i = 0, sw_rdata_o, v;
	logic [20:0] fa;
	logic [15:0] fdi, fdo, p;
	logic fce, fwe, frd, foe, ce_i = 1;
	int miscompares = 0, checked = 0;
	initial forever #5 clk_sys_i = ~clk_sys_i;
	nbp_ctrl #(.PROG_WAIT(20), .ERASE_WAIT(30)) nbp_ctrl_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
		.sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .flash_addr_o(fa),
		.flash_dq_i(fdi), .flash_dq_o(fdo), .flash_dq_oe_o(foe),
		.flash_ce_n_o(fce), .flash_we_n_o(fwe), .flash_oe_n_o(frd));
	nbp_flash_model nbp_flash_model_i (.addr_i(fa), .dq_i(fdo),
		.dq_o(fdi), .ce_n_i(fce), .we_n_i(fwe), .oe_n_i(frd),
		.drv_i(foe));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1;
		@(posedge clk_sys_i);
		sw_wr_i <= 0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		sw_addr_i <= a;
		sw_rd_i <= 1;
		@(posedge clk_sys_i);
		sw_rd_i <= 0;
		#1 v = sw_rdata_o;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] m);
		checked++;
		if ((v & m) !== e) begin
			miscompares++;
			$display("wrong value reg %h expected %h seen %h", sw_addr_i, e, v);
		end
	endtask
	// Launch, poll until idle, check the status flags
	// Unlock runs also freeze the clock enable and try a command while busy
	task automatic run(input logic [3:0] op, input logic [31:0] e);
		logic [31:0] hold;
		wr(8'h00, 32'(op));
		if (op == 4'd2) begin
			hold = 32'({fa, fce});
			ce_i <= 0;
			repeat (5) @(posedge clk_sys_i);
			v = 32'({fa, fce});
			ce_i <= 1;
			cmp(hold, '1);
			wr(8'h00, 32'h7);
		end
		for (int i = 0; i < 3000; i++) begin
			rd(8'h10);
			if (v[0] === 1'b0) break;
		end
		cmp(e, 32'h7);
	endtask
	task automatic summarize;
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#500us;
		miscompares++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 0;
		rd(8'h10); cmp(0, '1);
		rd(8'h30); cmp(0, '1);
		for (int i = 0; i < 4; i++) begin
			p = 16'h1357 * 16'(i + 3);
			wr(8'h0C, i);
			wr(8'h08, 32'(p));
			wr(8'h20 + 8'(4 * i), 32'(p));
			run(0, 2);
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h0C, i);
			run(1, 2);
			rd(8'h14); cmp(32'(16'h1357 * 16'(i + 3)), 'hFFFF);
		end
		run(7, 2);
		run(8, 2);
		rd(8'h14); cmp(2, 2);
		run(2, 2);
		rd(8'h00); cmp(2, 'hF);
		wr(8'h10, 2);
		rd(8'h10); cmp(0, 'h3);
		run(8, 2);
		rd(8'h14); cmp(0, 2);
		wr(8'h04, 5);
		run(9, 2);
		v = 32'(nbp_flash_model_i.dynamic_protect_bit[5]); cmp(1, 1);
		run(11, 2);
		rd(8'h14); cmp(1, 1);
		run(10, 2);
		run(11, 2);
		rd(8'h14); cmp(0, 1);
		wr(8'h04, 3);
		nbp_flash_model_i.bad = 1;
		run(3, 2);
		rd(8'h10); cmp(32'h20, 'hF0);
		run(5, 2);
		rd(8'h14); cmp(1, 1);
		run(6, 2);
		run(5, 2);
		rd(8'h14); cmp(0, 1);
		nbp_flash_model_i.bad = 4;
		run(3, 6);
		rd(8'h10); cmp(32'h40, 'hF0);
		for (int k = 14; k >= 12; k -= 2) begin
			run(4'(k), 2);
			run(4'(k + 1), 2);
			rd(8'h14); cmp(1, 1);
			if (k == 14) begin
				run(7, 2);
				run(2, 2);
				run(8, 2);
				rd(8'h14); cmp(2, 2);
			end
		end
		wr(8'h0C, 0);
		run(1, 2);
		rd(8'h14); cmp(32'hFFFF, 'hFFFF);
		run(4, 2);
		v = 32'(nbp_flash_model_i.master); cmp(1, 1);
		v = nbp_flash_model_i.late; cmp(0, '1);
		summarize;
	end
endmodule
